// File: nfc_host.v
// NAND flash host sequencer: command, address and data bytes on the flash pins.
// Assumes nfc_consts.vh, a 50 MHz clock, and the flash ready/busy pulled up externally.
`include "nfc_consts.vh"
module nfc_host (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [2:0]  req_op,
  input  wire [7:0]  req_cmd,
  input  wire [25:0] req_addr,
  input  wire [9:0]  req_len,
  input  wire [7:0]  wr_data,
  output wire        wr_data_ready,
  output reg  [7:0]  rd_data,
  output reg         rd_data_valid,
  output reg         op_done,
  output reg         cmd_refused,
  output wire        flash_busy,
  output reg         chip_sel_n,
  output reg         cmd_latch,
  output reg         addr_latch,
  output wire        wr_strobe_n,
  output wire        read_strobe_n,
  output reg  [7:0]  io_out,
  output reg         io_oe,
  input  wire [7:0]  io_in,
  input  wire        ready_busy_n
);
  localparam S_IDLE  = 3'd0;
  localparam S_CMD   = 3'd1;
  localparam S_ADDR  = 3'd2;
  localparam S_WDATA = 3'd3;
  localparam S_CONF  = 3'd4;
  localparam S_WAIT  = 3'd5;
  localparam S_RDATA = 3'd6;
  localparam S_BUSYW = 3'd7;

  reg [2:0]  state;
  reg [2:0]  op;
  reg [7:0]  cmd;
  reg [25:0] addr;
  reg [9:0]  count;
  reg [1:0]  acyc;
  wire [1:0] asel;
  reg        go;
  reg [7:0]  io_meta;
  reg [7:0]  io_sync;
  reg [1:0]  rb_meta;
  wire       rb_ready;
  wire       done;
  wire       rd_cyc;
  wire       legal;
  wire       busy_ok;
  reg [7:0]  addr_byte;

  // Two-stage synchronisers for pins
  always @(posedge clk) begin
    if (!rst_n) begin
      io_meta <= 8'h00;
      io_sync <= 8'h00;
      rb_meta <= 2'b11;
    end else if (ce) begin
      io_meta <= io_in;
      io_sync <= io_meta;
      rb_meta <= {rb_meta[0], ready_busy_n};
    end
  end
  assign rb_ready   = rb_meta[1];
  assign flash_busy = !rb_ready;

  assign legal = (req_cmd == `NFC_CMD_READ_A) || (req_cmd == `NFC_CMD_READ_B) ||
                 (req_cmd == `NFC_CMD_READ_C) || (req_cmd == `NFC_CMD_READ_IDENTIFICATION) ||
                 (req_cmd == `NFC_CMD_RESET) || (req_cmd == `NFC_CMD_PROG) ||
                 (req_cmd == `NFC_CMD_ERASE) || (req_cmd == `NFC_CMD_PROT1) ||
                 (req_cmd == `NFC_CMD_PROT2) || (req_cmd == `NFC_CMD_PROT3) ||
                 (req_cmd == `NFC_CMD_STATUS) || (req_cmd == `NFC_CMD_PROT_ST);
  assign busy_ok = (req_cmd == `NFC_CMD_RESET) || (req_cmd == `NFC_CMD_STATUS);

  assign req_ready     = (state == S_IDLE);
  assign wr_data_ready = (state == S_ADDR && done && acyc == 2'd3 && op == `NFC_OP_PROG &&
                          count != 10'h0) || (state == S_WDATA && done && count != 10'h1);
  assign rd_cyc        = (state == S_RDATA);
  // Next address byte is chosen on the cycle that ends the previous one
  assign asel          = (state == S_ADDR && done) ? acyc + 2'd1 : acyc;

  // Address cycle mapping
  always @* begin
    case (asel)
      2'd0:    addr_byte = addr[7:0];
      2'd1:    addr_byte = addr[16:9];
      2'd2:    addr_byte = addr[24:17];
      default: addr_byte = {7'h00, addr[25]};
    endcase
  end

  nfc_strobe u_strobe (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .go            (go),
    .is_read       (rd_cyc),
    .done          (done),
    .wr_strobe_n   (wr_strobe_n),
    .read_strobe_n (read_strobe_n)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      state         <= S_IDLE;
      op            <= `NFC_OP_SINGLE;
      cmd           <= 8'h00;
      addr          <= 26'h0;
      count         <= 10'h0;
      acyc          <= 2'd0;
      go            <= 1'b0;
      rd_data       <= 8'h00;
      rd_data_valid <= 1'b0;
      op_done       <= 1'b0;
      cmd_refused   <= 1'b0;
      chip_sel_n    <= 1'b1;
      cmd_latch     <= 1'b0;
      addr_latch    <= 1'b0;
      io_out        <= 8'h00;
      io_oe         <= 1'b0;
    end else if (ce) begin
      rd_data_valid <= 1'b0;
      op_done       <= 1'b0;
      cmd_refused   <= 1'b0;
      go            <= 1'b0;
      case (state)
        S_IDLE: begin
          if (req_valid) begin
            if (!legal || (!rb_ready && !busy_ok)) begin
              cmd_refused <= 1'b1;
            end else begin
              op         <= req_op;
              cmd        <= req_cmd;
              addr       <= req_addr;
              count      <= (req_len > `NFC_PAGE_BYTES) ? `NFC_PAGE_BYTES : req_len;
              acyc       <= (req_op == `NFC_OP_ERASE) ? 2'd1 : 2'd0;
              chip_sel_n <= 1'b0;
              cmd_latch  <= 1'b1;
              io_out     <= req_cmd;
              io_oe      <= 1'b1;
              go         <= 1'b1;
              state      <= S_CMD;
            end
          end
        end
        S_CMD: begin
          if (done) begin
            cmd_latch <= 1'b0;
            if (op == `NFC_OP_SINGLE || op == `NFC_OP_ID && cmd != `NFC_CMD_READ_IDENTIFICATION) begin
              state <= S_WAIT;
            end else if (op == `NFC_OP_ID) begin
              addr_latch <= 1'b1;
              io_out     <= 8'h00;
              acyc       <= 2'd3;
              go         <= 1'b1;
              state      <= S_ADDR;
            end else begin
              addr_latch <= 1'b1;
              io_out     <= addr_byte;
              go         <= 1'b1;
              state      <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (done) begin
            if (acyc == 2'd3) begin
              addr_latch <= 1'b0;
              if (op == `NFC_OP_PROG) begin
                state <= S_WDATA;
                io_out <= wr_data;
                go     <= (count != 10'h0);
                if (count == 10'h0)
                  state <= S_CONF;
              end else if (op == `NFC_OP_ERASE) begin
                state <= S_CONF;
              end else begin
                io_oe <= 1'b0;
                state <= (op == `NFC_OP_ID) ? S_RDATA : S_BUSYW;
              end
            end else begin
              acyc   <= acyc + 2'd1;
              io_out <= addr_byte;
              go     <= 1'b1;
              state  <= S_ADDR;
            end
          end
        end
        S_WDATA: begin
          if (done) begin
            count <= count - 10'h1;
            if (count == 10'h1) begin
              state <= S_CONF;
            end else begin
              io_out <= wr_data;
              go     <= 1'b1;
            end
          end
        end
        S_CONF: begin
          if (!go && !cmd_latch) begin
            cmd_latch <= 1'b1;
            io_out    <= (op == `NFC_OP_ERASE) ? `NFC_CMD_ERASE_GO : `NFC_CMD_PROG_GO;
            go        <= 1'b1;
          end else if (done) begin
            cmd_latch <= 1'b0;
            io_oe     <= 1'b0;
            state     <= S_BUSYW;
          end
        end
        S_BUSYW: begin
          if (!rb_ready) begin
            state <= S_WAIT;
          end else if (count == 10'h0 || op != `NFC_OP_READ) begin
            count <= 10'h0;
          end
        end
        S_WAIT: begin
          if (rb_ready) begin
            io_oe <= 1'b0;
            if (op == `NFC_OP_READ || op == `NFC_OP_ID || cmd == `NFC_CMD_STATUS ||
                cmd == `NFC_CMD_PROT_ST) begin
              if (count == 10'h0) begin
                chip_sel_n <= 1'b1;
                op_done    <= 1'b1;
                state      <= S_IDLE;
              end else begin
                go    <= 1'b1;
                state <= S_RDATA;
              end
            end else begin
              chip_sel_n <= 1'b1;
              op_done    <= 1'b1;
              state      <= S_IDLE;
            end
          end
        end
        S_RDATA: begin
          if (count == 10'h0) begin
            chip_sel_n <= 1'b1;
            op_done    <= 1'b1;
            state      <= S_IDLE;
          end else if (done) begin
            rd_data       <= io_sync;
            rd_data_valid <= 1'b1;
            count         <= count - 10'h1;
            go            <= (count != 10'h1);
          end else if (!go && !read_strobe_n == 1'b0) begin
            go <= 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// File: nfc_consts.vh
// Constants of the NAND flash host controller: command codes, address map, timing.
// Assumes a 50 MHz clock; included by nfc_host.v and nfc_strobe.v.
`ifndef NFC_CONSTS_VH
`define NFC_CONSTS_VH
`define NFC_CMD_READ_A     8'h00
`define NFC_CMD_READ_B     8'h01
`define NFC_CMD_READ_C     8'h50
`define NFC_CMD_READ_IDENTIFICATION    8'h90
`define NFC_CMD_RESET      8'hff
`define NFC_CMD_PROG       8'h80
`define NFC_CMD_PROG_GO    8'h10
`define NFC_CMD_ERASE      8'h60
`define NFC_CMD_ERASE_GO   8'hd0
`define NFC_CMD_PROT1      8'h41
`define NFC_CMD_PROT2      8'h42
`define NFC_CMD_PROT3      8'h43
`define NFC_CMD_STATUS     8'h70
`define NFC_CMD_PROT_ST    8'h7a
`define NFC_OP_READ        3'h0
`define NFC_OP_PROG        3'h1
`define NFC_OP_ERASE       3'h2
`define NFC_OP_SINGLE      3'h3
`define NFC_OP_ID          3'h4
`define NFC_PAGE_BYTES     10'd528
`define NFC_SPARE_START    10'd512
`define NFC_HALF_BIT       8
`define NFC_PAGE_LSB       9
`define NFC_BLOCK_LSB      14
`define NFC_ADDR_W         26
`define NFC_STROBE_CYC     4'h2
`endif

// File: nfc_strobe.v
// One bus cycle on the flash pins: drives write or read strobe low for a fixed time.
// Assumes nfc_consts.vh and a 50 MHz clock; pins sampled by the caller.
`include "nfc_consts.vh"
module nfc_strobe (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       go,
  input  wire       is_read,
  output wire       done,
  output reg        wr_strobe_n,
  output reg        read_strobe_n
);
  reg [3:0] cnt;
  reg       active;
  assign done = active && (cnt == 4'h0) && ce;
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt           <= 4'h0;
      active        <= 1'b0;
      wr_strobe_n   <= 1'b1;
      read_strobe_n <= 1'b1;
    end else if (ce) begin
      if (go && !active) begin
        active <= 1'b1;
        cnt    <= `NFC_STROBE_CYC;
        if (is_read)
          read_strobe_n <= 1'b0;
        else
          wr_strobe_n   <= 1'b0;
      end else if (active) begin
        if (cnt == 4'h1) begin
          wr_strobe_n   <= 1'b1;
          read_strobe_n <= 1'b1;
        end
        if (cnt == 4'h0)
          active <= 1'b0;
        else
          cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// File: nfc_host_asserts.sv
// Checker of nfc_host pin sequencing and request refusal.
// Assumes binding to nfc_host with ce held high.
module nfc_host_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_cmd,
  input wire logic       cmd_refused,
  input wire logic       flash_busy,
  input wire logic       chip_sel_n,
  input wire logic       cmd_latch,
  input wire logic       addr_latch,
  input wire logic       wr_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic       io_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = req_valid && req_ready;
  sequence s_wr_low;
    !wr_strobe_n[*2] ##1 wr_strobe_n;
  endsequence
  property p_latch_excl; !(cmd_latch && addr_latch); endproperty
  property p_wr_sel; !wr_strobe_n |-> !chip_sel_n && io_oe; endproperty
  property p_wr_pulse; $fell(wr_strobe_n) |-> s_wr_low; endproperty
  property p_io_hold;
    !wr_strobe_n |-> $stable(io_out) && $stable(cmd_latch) && $stable(addr_latch);
  endproperty
  property p_no_rw; !(!wr_strobe_n && !read_strobe_n); endproperty
  property p_rd_hiz; !read_strobe_n |-> !io_oe && !chip_sel_n; endproperty
  property p_undef;
    take && !(req_cmd inside {8'h00, 8'h01, 8'h50, 8'h90, 8'hff, 8'h80, 8'h60,
      8'h41, 8'h42, 8'h43, 8'h70, 8'h7a}) |-> ##[1:2] cmd_refused;
  endproperty
  property p_busy;
    take && flash_busy && !(req_cmd inside {8'hff, 8'h70}) |-> ##[1:2] cmd_refused;
  endproperty
  property p_quiet; cmd_refused |-> !cmd_latch && wr_strobe_n; endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width");
  a_io_hold: assert property (p_io_hold) else $error("bus moved under strobe");
  a_no_rw: assert property (p_no_rw) else $error("both strobes low");
  a_rd_hiz: assert property (p_rd_hiz) else $error("driving bus in read");
  a_undef: assert property (p_undef) else $error("undefined code accepted");
  a_busy: assert property (p_busy) else $error("code accepted while busy");
  a_quiet: assert property (p_quiet) else $error("refused code sent");
endmodule

bind nfc_host nfc_host_asserts u_nfc_host_asserts (.clk(clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
  .cmd_refused(cmd_refused), .flash_busy(flash_busy), .chip_sel_n(chip_sel_n),
  .cmd_latch(cmd_latch), .addr_latch(addr_latch), .wr_strobe_n(wr_strobe_n),
  .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe));

// File: nfc_flash_model.sv
// Behavioural flash device: logs bus bytes, serves reads, pulls busy low.
// Assumes strobes from nfc_host; busy time set by BUSY_NS.
module nfc_flash_model #(
  parameter int BUSY_NS = 400
) (
  input  wire logic       chip_sel_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       wr_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] io_out,
  input  wire logic       io_oe,
  output logic      [7:0] io_in,
  output logic            ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] log_q[$];
  logic [9:0] col;
  logic [7:0] last_cmd;
  logic       half;
  int         na;
  initial begin
    ready_busy_n = 1'b1;
    io_in = 8'h00;
    half = 1'b0;
    na = 0;
    col = 10'h000;
    last_cmd = 8'h00;
  end
  task automatic go_busy;
    ready_busy_n = 1'b0;
    #(BUSY_NS);
    ready_busy_n = 1'b1;
  endtask
  always @(posedge wr_strobe_n) if (!chip_sel_n) begin
    log_q.push_back({cmd_latch, addr_latch, io_out});
    if (cmd_latch) begin
      last_cmd = io_out;
      na = 0;
      if (io_out == 8'h01 || io_out == 8'h00) half = io_out[0];
      if (io_out == 8'h10 || io_out == 8'hd0) go_busy;
    end else if (addr_latch) begin
      na++;
      if (na == 1 && last_cmd == 8'h50) col = 10'd512 + io_out[3:0];
      else if (na == 1 && last_cmd != 8'h60) col = {1'b0, half, io_out};
      if (na == 4 && last_cmd inside {8'h00, 8'h01, 8'h50}) go_busy;
    end
  end
  always @(negedge read_strobe_n) begin
    io_in = col[7:0] ^ {6'h16, col[9:8]};
    col = col + 10'd1;
    half = 1'b0;
  end
  always @(posedge read_strobe_n) #10 io_in = ~io_in;
endmodule

// File: test_nfc_host.sv
// Self-checking bench of nfc_host against the behavioural flash model.
// Assumes nfc_consts.vh on the include path and a 50 MHz clock.
`include "nfc_consts.vh"
module test_nfc_host;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [2:0] op; logic [7:0] cmd; logic ref_exp; } nfc_row_t;
  localparam logic [25:0] A = 26'h2b4_c3a7;
  logic clk, rst_n, ce, req_valid, refused;
  logic [2:0] req_op;
  logic [7:0] req_cmd, wr_data;
  logic [25:0] req_addr;
  logic [9:0] req_len;
  wire logic req_ready, wr_data_ready, rd_data_valid, op_done, cmd_refused, flash_busy;
  wire logic chip_sel_n, cmd_latch, addr_latch, wr_strobe_n, read_strobe_n, io_oe, rb_n;
  wire logic [7:0] rd_data, io_out, io_in;
  logic [7:0] rd_q[$];
  int mismatches, checks_done;
  nfc_row_t rows[8] = '{'{3'h3, 8'hff, 0}, '{3'h3, 8'h70, 0}, '{3'h3, 8'h7a, 0},
    '{3'h3, 8'h41, 0}, '{3'h3, 8'h42, 0}, '{3'h3, 8'h43, 0}, '{3'h4, 8'h90, 0},
    '{3'h3, 8'h33, 1}};
  nfc_host u_nfc_host (.clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_len(req_len), .wr_data(wr_data), .wr_data_ready(wr_data_ready),
    .rd_data(rd_data), .rd_data_valid(rd_data_valid), .op_done(op_done),
    .cmd_refused(cmd_refused), .flash_busy(flash_busy), .chip_sel_n(chip_sel_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .wr_strobe_n(wr_strobe_n),
    .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(rb_n));
  nfc_flash_model u_nfc_flash_model (.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .wr_strobe_n(wr_strobe_n), .read_strobe_n(read_strobe_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(rb_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (rd_data_valid === 1'b1) rd_q.push_back(rd_data);
  always @(posedge clk) if (wr_data_ready === 1'b1) wr_data <= wr_data + 8'h01;
  task summarize;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_log(input logic [9:0] e[$]);
    chk("log_len", 10'(e.size()), 10'(u_nfc_flash_model.log_q.size()));
    foreach (e[k]) chk("log_byte", e[k], u_nfc_flash_model.log_q[k]);
  endtask
  task run(input logic [2:0] op, input logic [7:0] cmd, input logic [25:0] a,
           input logic [9:0] n);
    int i;
    u_nfc_flash_model.log_q.delete();
    rd_q.delete();
    @(posedge clk);
    req_op <= op;
    req_cmd <= cmd;
    req_addr <= a;
    req_len <= n;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    for (i = 0; i < 5000 && op_done !== 1'b1 && cmd_refused !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    refused = (cmd_refused === 1'b1);
    if (i == 5000) begin
      mismatches++;
      $display("[FAIL] completion expected 1 seen 0");
      summarize;
    end
  endtask
  task rd_chk(input logic [7:0] cmd, input logic [25:0] a, input logic [9:0] base);
    logic [9:0] c;
    run(3'h0, cmd, a, 10'd3);
    chk("rd_log_len", 10'd5, 10'(u_nfc_flash_model.log_q.size()));
    chk("rd_count", 10'd3, 10'(rd_q.size()));
    for (int i = 0; i < 3; i++) begin
      c = base + 10'(i);
      chk("rd_byte", {2'b00, c[7:0] ^ {6'h16, c[9:8]}}, {2'b00, rd_q[i]});
    end
    $display("Read test %h done", cmd);
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req_op = 3'h0;
    req_cmd = 8'h00;
    req_addr = 26'h0;
    req_len = 10'h0;
    wr_data = 8'h30;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("idle_pins", 10'h038, {4'h0, chip_sel_n, wr_strobe_n, read_strobe_n, io_oe,
      cmd_latch, addr_latch});
    repeat (2) @(posedge clk);
    $display("Reset test done");
    foreach (rows[k]) begin
      run(rows[k].op, rows[k].cmd, 26'h0, 10'h0);
      chk("refused", {9'h0, rows[k].ref_exp}, {9'h0, refused});
      if (rows[k].ref_exp) chk("log_len", 10'h0, 10'(u_nfc_flash_model.log_q.size()));
      else chk("cmd", {2'b10, rows[k].cmd}, u_nfc_flash_model.log_q[0]);
      $display("Row %0d done", k);
    end
    run(3'h1, `NFC_CMD_PROG, A, 10'd2);
    chk_log('{{2'b10, 8'h80}, {2'b01, A[7:0]}, {2'b01, A[16:9]}, {2'b01, A[24:17]},
      {2'b01, 7'h0, A[25]}, 10'h030, 10'h031, {2'b10, 8'h10}});
    $display("Program test done");
    run(3'h2, `NFC_CMD_ERASE, A, 10'd0);
    chk_log('{10'h260, {2'b01, A[16:9]}, {2'b01, A[24:17]}, {2'b01, 7'h0, A[25]},
      10'h2d0});
    $display("Erase test done");
    rd_chk(`NFC_CMD_READ_B, 26'h5, 10'd261);
    rd_chk(`NFC_CMD_READ_A, 26'h5, 10'd5);
    rd_chk(`NFC_CMD_READ_C, 26'h3, 10'd515);
    fork
      u_nfc_flash_model.go_busy();
    join_none
    repeat (3) @(posedge clk);
    #1 chk("busy_flag", 10'h001, {9'h0, flash_busy});
    run(3'h3, `NFC_CMD_PROT1, 26'h0, 10'h0);
    chk("busy_refused", 10'h001, {9'h0, refused});
    chk("busy_log", 10'h000, 10'(u_nfc_flash_model.log_q.size()));
    run(3'h3, `NFC_CMD_STATUS, 26'h0, 10'h0);
    chk("busy_taken", 10'h000, {9'h0, refused});
    chk("busy_status", {2'b10, `NFC_CMD_STATUS}, u_nfc_flash_model.log_q[0]);
    chk("busy_end", 10'h000, {9'h0, flash_busy});
    $display("Busy test done");
    summarize;
  end
endmodule
